//--- include/lpsc_pkg.sv
// Package with register map, field layout and reset values of the PLL and system clock control
package lpsc_pkg;
   // Register word indices; the port decodes byte addresses, four bytes per word
   localparam logic [7:0] LPSC_PLL_CONTROL_IDX = 8'hb9;
   localparam logic [7:0] LPSC_PLL_CONFIGURATION_IDX = 8'hba;
   localparam int LPSC_ADDR_W = 10;
   // Field positions in the control register
   localparam int LPSC_CLKDIV_HI = 15;
   localparam int LPSC_CLKDIV_LO = 14;
   localparam int LPSC_CLKOFF_BIT = 13;
   localparam int LPSC_PLLEN_BIT = 0;
   // Field positions in the configuration register
   localparam int LPSC_RANGE_HI = 15;
   localparam int LPSC_RANGE_LO = 14;
   localparam int LPSC_PREDIV_HI = 12;
   localparam int LPSC_PREDIV_LO = 8;
   localparam int LPSC_MULT_HI = 7;
   localparam int LPSC_MULT_LO = 0;
   // Reset values
   localparam logic [1:0] LPSC_CLKDIV_RST = 2'h0;
   localparam logic LPSC_CLKOFF_RST = 1'b0;
   localparam logic LPSC_PLLEN_RST = 1'b0;
   localparam logic [1:0] LPSC_RANGE_RST = 2'h2;
   localparam logic [4:0] LPSC_PREDIV_RST = 5'h01;
   localparam logic [7:0] LPSC_MULT_RST = 8'h20;
   // System clock divider codes
   typedef enum logic [1:0] {LPSC_DIV1, LPSC_DIV2, LPSC_DIV4, LPSC_DIV8} lpsc_clkdiv_t;
endpackage

//--- rtl/lpsc_sysclk_div.sv
// System clock divider and output gate
`timescale 1ns/100ps
`default_nettype none
module lpsc_sysclk_div
   import lpsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic src_clk_in,
   input wire logic [1:0] div_sel,
   input wire logic out_disable,
   output logic sysclk_out
);
   ///////////////////////////////////////////////////////////////////////////
   logic sync1_reg; // First synchroniser stage
   logic sync2_reg; // Second synchroniser stage
   logic prev_reg; // Last sample for edge detection
   logic [2:0] cnt_reg; // Rising edge counter
   logic rise; // Source rising edge

   // Synchronise the source clock pin
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         sync1_reg <= src_clk_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign rise = sync2_reg & ~prev_reg;

   // Count source edges; counter bits form divided clocks
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cnt_reg <= 3'h0;
      end else if (rise) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   // Select and gate the output
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sysclk_out <= 1'b0;
      end else if (out_disable) begin
         sysclk_out <= 1'b0;
      end else begin
         case (lpsc_clkdiv_t'(div_sel))
            LPSC_DIV1: sysclk_out <= sync2_reg;
            LPSC_DIV2: sysclk_out <= cnt_reg[0];
            LPSC_DIV4: sysclk_out <= cnt_reg[1];
            default: sysclk_out <= cnt_reg[2];
         endcase
      end
   end
endmodule
`default_nettype wire

//--- rtl/lpsc_top.sv
// PLL control and system clock output control with register port
//
// Function
// - Divide source clock by 1,2,4,8 for sysclk
// - Disable bit stops system clock output
// - Enable bit powers PLL; resets to 0
// - Range field selects band; resets 2
// - Config writes ignored by PLL while enabled
// - Pre-divider codes 0,1 mean 1; reset 1
// - Reference equals input over pre-divider
// - Multiplier codes 0,1 mean 1; reset 0x20
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lpsc_top
   import lpsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic tx_clk_in,
   output logic sysclk_out,
   output logic pll_power_enable,
   output logic [1:0] freq_range_select,
   output logic [4:0] pll_pre_divider,
   output logic [7:0] pll_multiplier
);
   ///////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [1:0] sysclk_divider_reg; // Software divider select
   logic sysclk_out_disable_reg; // Software output disable
   logic pll_en_reg; // Software PLL enable
   logic [1:0] range_reg; // Software range field
   logic [4:0] prediv_reg; // Software pre-divider field
   logic [7:0] mult_reg; // Software multiplier field
   logic sel_ctl; // Control register addressed
   logic sel_cfg; // Configuration register addressed
   logic ctl_wr; // Write aimed at the control register
   logic cfg_wr; // Write aimed at the configuration register
   logic ctl_rd; // Read aimed at the control register
   logic cfg_rd; // Read aimed at the configuration register
   logic [15:0] ctl_word; // Control register as software sees it
   logic [15:0] cfg_word; // Configuration register as software sees it

   // Byte address to word index compare
   function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   // Map a code where 0 and 1 both mean one
   function automatic logic [7:0] eff_val(input logic [7:0] code);
      eff_val = (code == 8'h00) ? 8'h01 : code;
   endfunction

   assign sel_ctl = hit(reg_addr, LPSC_PLL_CONTROL_IDX);
   assign sel_cfg = hit(reg_addr, LPSC_PLL_CONFIGURATION_IDX);

   // Strobes qualified by the decoded register
   assign ctl_wr = reg_wr & sel_ctl;
   assign cfg_wr = reg_wr & sel_cfg;
   assign ctl_rd = reg_rd & sel_ctl;
   assign cfg_rd = reg_rd & sel_cfg;

   // Read views; reserved positions are tied low so no stale bit leaks out
   assign ctl_word = {sysclk_divider_reg, sysclk_out_disable_reg, 12'h000, pll_en_reg};
   assign cfg_word = {range_reg, 1'b0, prediv_reg, mult_reg};

   ///////////////////////////////////////////////////////////////////////////
   // Control register writes
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sysclk_divider_reg <= LPSC_CLKDIV_RST;
         sysclk_out_disable_reg <= LPSC_CLKOFF_RST;
         pll_en_reg <= LPSC_PLLEN_RST;
      end else if (ctl_wr) begin
         // Reserved bits are simply not stored
         sysclk_divider_reg <= reg_wdata[LPSC_CLKDIV_HI:LPSC_CLKDIV_LO];
         sysclk_out_disable_reg <= reg_wdata[LPSC_CLKOFF_BIT];
         pll_en_reg <= reg_wdata[LPSC_PLLEN_BIT];
      end
   end

   // Configuration register writes; storage always accepts the value
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         range_reg <= LPSC_RANGE_RST;
         prediv_reg <= LPSC_PREDIV_RST;
         mult_reg <= LPSC_MULT_RST;
      end else if (cfg_wr) begin
         // Stored even while running; applied only after power down
         range_reg <= reg_wdata[LPSC_RANGE_HI:LPSC_RANGE_LO];
         prediv_reg <= reg_wdata[LPSC_PREDIV_HI:LPSC_PREDIV_LO];
         mult_reg <= reg_wdata[LPSC_MULT_HI:LPSC_MULT_LO];
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // PLL settings: frozen while the PLL runs
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pll_power_enable <= LPSC_PLLEN_RST;
         freq_range_select <= LPSC_RANGE_RST;
         pll_pre_divider <= LPSC_PREDIV_RST;
         pll_multiplier <= LPSC_MULT_RST;
      end else begin
         pll_power_enable <= pll_en_reg;
         if (!pll_en_reg) begin
            // Load only while powered down; the hold covers changes during run
            freq_range_select <= range_reg;
            pll_pre_divider <= 5'(eff_val({3'h0, prediv_reg}));
            pll_multiplier <= eff_val(mult_reg);
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (ctl_rd) begin
         // Control word
         reg_rdata <= ctl_word;
      end else if (cfg_rd) begin
         // Configuration word
         reg_rdata <= cfg_word;
      end else begin
         // Idle or unmapped address: bus rests at zero
         reg_rdata <= 16'h0000;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // System clock divider
   lpsc_sysclk_div u_div (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .src_clk_in(tx_clk_in),
      .div_sel(sysclk_divider_reg),
      .out_disable(sysclk_out_disable_reg),
      .sysclk_out(sysclk_out)
   );

   ///////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // Enable output follows a control write two edges later
   pen_follows_a: assert property (ctl_wr |=> ##1
      pll_power_enable == $past(reg_wdata[LPSC_PLLEN_BIT], 2))
      else $error("PLL enable did not follow write");
   // A stored zero enable always powers the PLL down on the next edge
   pen_low_a: assert property (!pll_en_reg |=> !pll_power_enable)
      else $error("PLL not powered down");
   // Settings stay frozen while the PLL runs
   freeze_run_a: assert property ((pll_en_reg && pll_power_enable) |=>
      $stable(pll_multiplier) && $stable(pll_pre_divider) && $stable(freq_range_select))
      else $error("PLL settings changed while running");
   // Multiplier codes zero and one both give one
   ns_map_a: assert property ((!pll_en_reg && $past(!pll_en_reg)) |=>
      pll_multiplier == (($past(mult_reg) == 8'h00) ? 8'h01 : $past(mult_reg)))
      else $error("Multiplier mapping wrong");
   // Pre-divider codes zero and one both give one
   ms_map_a: assert property (!pll_en_reg |=>
      pll_pre_divider == (($past(prediv_reg) == 5'h00) ? 5'h01 : $past(prediv_reg)))
      else $error("Pre-divider mapping wrong");
   // Range loads straight through while powered down
   fr_load_a: assert property (!pll_en_reg |=> freq_range_select == $past(range_reg))
      else $error("Range not loaded");
   // Reserved positions read as zero
   rsv_ctl_a: assert property (ctl_rd |=> reg_rdata[12:1] == 12'h000)
      else $error("Reserved control bits not zero");
   rsv_cfg_a: assert property (cfg_rd |=> reg_rdata[13] == 1'b0)
      else $error("Reserved config bit not zero");
   // Output held low once the disable has settled
   sys_off_a: assert property (sysclk_out_disable_reg [*2] |=> !sysclk_out)
      else $error("System clock not gated");
   // Multiplier field reads back as written
   rd_back_a: assert property (cfg_rd |=>
      reg_rdata[7:0] == $past(mult_reg))
      else $error("Readback mismatch");
   // Enable and disable bits of the control word read back as written
   rd_ctl_a: assert property (ctl_rd |=> reg_rdata[0] == $past(pll_en_reg)
      && reg_rdata[13] == $past(sysclk_out_disable_reg))
      else $error("Control readback mismatch");
   // Read data rests at zero outside the answer cycle
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("Read data not idle");

   // Main scenarios
   cov_run_c: cover property (!pll_en_reg ##1 pll_en_reg);
   cov_wr_run_c: cover property (pll_en_reg && cfg_wr);
   cov_div8_c: cover property (sysclk_divider_reg == 2'h3 && !sysclk_out_disable_reg && sysclk_out);
   cov_off_c: cover property (sysclk_out_disable_reg && !sysclk_out);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the PLL and system clock control block
`timescale 1ns/100ps
`default_nettype none
module tb
   import lpsc_pkg::*;
;
   localparam logic [9:0] A_CTL = {LPSC_PLL_CONTROL_IDX, 2'b00}; // Control byte address
   localparam logic [9:0] A_CFG = {LPSC_PLL_CONFIGURATION_IDX, 2'b00}; // Config byte address
   logic ref_clk = 1'b0; // 200 MHz clock
   logic reset_n, reg_wr, reg_rd, sysclk_out, pll_power_enable;
   logic tx_clk_in = 1'b0; // Source clock pin, driven only by the clock process
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0] freq_range_select;
   logic [4:0] pll_pre_divider;
   logic [7:0] pll_multiplier;
   logic [2:0] tx_cnt = 3'h0; // Source clock half-period counter
   int n_fail = 0;
   int comparisons = 0;

   lpsc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_clk_in(tx_clk_in), .sysclk_out(sysclk_out), .pll_power_enable(pll_power_enable),
      .freq_range_select(freq_range_select), .pll_pre_divider(pll_pre_divider),
      .pll_multiplier(pll_multiplier));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a 12.5 MHz source clock kept well inside the input band
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      tx_cnt <= tx_cnt + 3'h1;
      if (tx_cnt == 3'h7) begin
         tx_clk_in <= ~tx_clk_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, report and close
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t ns: seen %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Register port accesses; each ends one idle edge later so strobes never clash
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge ref_clk);
   endtask
   // Applied PLL settings, sampled once the load edge has passed
   task automatic outs(input logic e, input logic [1:0] f, input logic [4:0] p,
         input logic [7:0] m);
      @(posedge ref_clk);
      #1 chk({pll_power_enable, freq_range_select, pll_pre_divider, pll_multiplier}, {e, f, p, m});
   endtask
   // Cycles between two rising edges of the system clock output
   task automatic per(input logic [1:0] d);
      int n, k;
      logic p;
      n = 0;
      k = 0;
      repeat (300) @(posedge ref_clk);
      p = sysclk_out;
      while (k < 2 && n < 3000) begin
         @(posedge ref_clk);
         #1 n++;
         if (sysclk_out === 1'b1 && p !== 1'b1) begin
            k++;
            if (k == 1) begin
               n = 0;
            end
         end
         p = sysclk_out;
      end
      chk(16'(n), 16'(16 << d));
   endtask
   // Output must stay low for a long stretch
   task automatic quiet;
      int k;
      k = 0;
      repeat (50) @(posedge ref_clk);
      repeat (400) begin
         @(posedge ref_clk);
         #1 if (sysclk_out !== 1'b0) k++;
      end
      chk(16'(k), 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      reset_n = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(A_CTL, 16'h0000);
      rd(A_CFG, 16'h8120);
      outs(1'b0, 2'h2, 5'h01, 8'h20);
      wr(A_CFG, 16'h8028);
      outs(1'b0, 2'h2, 5'h01, 8'h28);
      wr(A_CFG, 16'hffff);
      rd(A_CFG, 16'hdfff);
      outs(1'b0, 2'h3, 5'h1f, 8'hff);
      wr(A_CFG, 16'h0000);
      outs(1'b0, 2'h0, 5'h01, 8'h01);
      wr(A_CTL, 16'hffff);
      rd(A_CTL, 16'he001);
      outs(1'b1, 2'h0, 5'h01, 8'h01);
      wr(A_CFG, 16'h4305);
      rd(A_CFG, 16'h4305);
      outs(1'b1, 2'h0, 5'h01, 8'h01);
      wr(A_CTL, 16'h0000);
      outs(1'b0, 2'h1, 5'h03, 8'h05);
      wr(10'h2ec, 16'hffff);
      rd(10'h2ec, 16'h0000);
      rd(A_CTL, 16'h0000);
      for (int d = 0; d < 4; d++) begin
         wr(A_CTL, {2'(d), 14'h0000});
         per(2'(d));
      end
      wr(A_CTL, 16'h2000);
      quiet;
      wr(A_CTL, 16'h0000);
      per(2'h0);
      summarize;
   end

   // Watchdog against a hang
   initial begin
      #400000;
      n_fail++;
      summarize;
   end
endmodule
`default_nettype wire
